// ===== e1tx_map.svh
// Constant map for the E1 transmit framer: offsets, fields, resets, timing
`ifndef E1TX_MAP_SVH
`define E1TX_MAP_SVH

// Synchronised pin vector
`define E1TX_PIN_W 8
`define E1TX_PIN_LCLK 0
`define E1TX_PIN_SCLK 1
`define E1TX_PIN_SER 2
`define E1TX_PIN_SIG 3
`define E1TX_PIN_LINK 4
`define E1TX_PIN_SYNC 5
`define E1TX_PIN_SSYNC 6
`define E1TX_PIN_FMS 7

// APB byte addresses
`define E1TX_ADDR_W 12
`define E1TX_ADDR_CTRL 12'h000
`define E1TX_ADDR_CHBLK 12'h004
`define E1TX_ADDR_STAT 12'h008

// Control register fields and reset
`define E1TX_CTRL_ES_EN 0
`define E1TX_CTRL_NRZ 1
`define E1TX_CTRL_SYNC_OUT 2
`define E1TX_CTRL_SYNC_MF 3
`define E1TX_CTRL_LINK_EN 4
`define E1TX_CTRL_SIG_EN 5
`define E1TX_CTRL_SA_LSB 8
`define E1TX_CTRL_SA_MSB 12
`define E1TX_CTRL_MASK 32'h0000_1F3F
`define E1TX_CTRL_RST 32'h0000_0000
`define E1TX_CHBLK_RST 32'h0000_0000

// Frame overhead words and positions
`define E1TX_FAS_WORD 8'h9B
`define E1TX_NFAS_HEAD 3'h6
`define E1TX_MAS_WORD 8'h0B
`define E1TX_TS_CAS 5'h10
`define E1TX_SA_FIRST_BIT 3'h3

// Timing
`define E1TX_FRAME_US 125
`define E1TX_LINE_KHZ 2048
`define E1TX_TIMESLOTS 32
`define E1TX_STORE_BITS 512

`endif

// ===== e1tx_pkg.sv
// Types shared by the E1 transmit framer modules
`default_nettype none
`include "e1tx_map.svh"
package e1tx_pkg;

   typedef struct packed {
      logic [3:0] frame;
      logic [4:0] ts;
      logic [2:0] bit_no;
   } e1tx_pos_t;

   typedef struct packed {
      logic [`E1TX_PIN_W-1:0] ff1;
      logic [`E1TX_PIN_W-1:0] ff2;
      logic [`E1TX_PIN_W-1:0] ff3;
   } e1tx_sync_st_t;

   typedef struct packed {
      logic [`E1TX_STORE_BITS-1:0][1:0] mem;
      logic [8:0] wptr;
   } e1tx_es_st_t;

   typedef struct packed {
      e1tx_pos_t pos;
      logic ser_s;
      logic sig_s;
      logic link_s;
      logic ami_pol;
      logic tx_pos;
      logic tx_neg;
      logic chclk;
      logic chblk;
      logic lclk;
      logic sync_out;
      logic sync_oe_n;
      logic [31:0] ctrl;
      logic [31:0] chblk_mask;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } e1tx_core_st_t;

endpackage
`default_nettype wire

// ===== e1tx_pin_sync.sv
// Two-stage pin synchroniser with edge detection on the second stage
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_map.svh"
module e1tx_pin_sync (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [`E1TX_PIN_W-1:0] i_pins,
   output logic [`E1TX_PIN_W-1:0] o_level,
   output logic [`E1TX_PIN_W-1:0] o_rise,
   output logic [`E1TX_PIN_W-1:0] o_fall
);
   e1tx_pkg::e1tx_sync_st_t s;
   e1tx_pkg::e1tx_sync_st_t next_s;

   always_comb begin
      next_s = s;
      next_s.ff1 = i_pins;
      next_s.ff2 = s.ff1;
      next_s.ff3 = s.ff2;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_level = s.ff2;
   assign o_rise = s.ff2 & ~s.ff3;
   assign o_fall = ~s.ff2 & s.ff3;
endmodule
`default_nettype wire

// ===== e1tx_elastic.sv
// Two-frame transmit elastic store, written from the system clock side
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_map.svh"
module e1tx_elastic (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_enable,
   input wire logic i_wr_stb,
   input wire logic i_sync,
   input wire logic [1:0] i_wr_data,
   input wire logic [8:0] i_rd_addr,
   output logic [1:0] o_rd_data,
   output logic [8:0] o_wptr
);
   e1tx_pkg::e1tx_es_st_t s;
   e1tx_pkg::e1tx_es_st_t next_s;
   logic [8:0] wr_addr;

   always_comb begin
      next_s = s;
      wr_addr = i_sync ? 9'h000 : s.wptr;
      if (i_enable && i_wr_stb) begin
         next_s.mem[wr_addr] = i_wr_data;
         next_s.wptr = wr_addr + 9'h001;
      end else if (i_enable && i_sync) begin
         next_s.wptr = 9'h000;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign o_rd_data = s.mem[i_rd_addr];
   assign o_wptr = s.wptr;

   AST_ES_SYNC: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_enable && i_sync |=> s.wptr <= 9'h001)
      else $error("Store write pointer not realigned by system sync");
endmodule
`default_nettype wire

// ===== e1tx_framer.sv
// E1 transmit formatter with channel strobes, link insertion and APB registers
// Behaviour
// - A 125 us frame holds 32 eight-bit timeslots, timeslot 0 first.
// - Bits 1 to 8 per timeslot, most significant bit sent first.
// - Channel n maps to timeslot n-1; channel 1 is timeslot 0.
// - The 2.048 MHz line clock paces the whole formatter.
// - Serial data sampled on line clock fall, or system clock fall with store.
// - Transmit store enabled and disabled on its own control bit.
// - Channel clock 256 kHz, high during each channel LSB, clock per store.
// - Channel clock only in legacy mode, feature-set select high.
// - Channel block set per channel over 32 channels, clock per store.
// - Link demand clock, 4 to 20 kHz, requests each link bit.
// - Link data sampled on line clock fall into chosen Sa4 to Sa8 bits.
// - Sync pin takes a boundary pulse or drives a frame or multiframe pulse.
// - Full-feature mode: signaling input sampled like data, inserted in stream.
// - Positive and negative outputs carry bipolar data, updated on line rise.
// - Output format bit set puts NRZ data on the positive output.
// - Formatter inserts all frame and multiframe overhead; multiframe word only in full-feature mode with signaling enabled.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_map.svh"
module e1tx_framer (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [`E1TX_ADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   input wire logic i_tx_line_clock,
   input wire logic i_tx_system_clock,
   input wire logic i_tx_ser,
   input wire logic i_tx_sig,
   input wire logic i_tx_link_data,
   input wire logic i_tx_sync,
   input wire logic i_tx_sys_sync,
   input wire logic i_feature_set_select,
   output logic o_tx_pos,
   output logic o_tx_neg,
   output logic o_tx_channel_clock,
   output logic o_tx_channel_block,
   output logic o_tx_link_demand_clock,
   output logic o_tx_sync,
   output logic o_tx_sync_oe_n
);
   localparam logic [7:0] FAS = `E1TX_FAS_WORD;
   localparam logic [2:0] NFAS = `E1TX_NFAS_HEAD;
   localparam logic [7:0] MAS = `E1TX_MAS_WORD;

   e1tx_pkg::e1tx_core_st_t s;
   e1tx_pkg::e1tx_core_st_t next_s;
   e1tx_pkg::e1tx_pos_t np;
   logic [`E1TX_PIN_W-1:0] pins;
   logic [`E1TX_PIN_W-1:0] lvl;
   logic [`E1TX_PIN_W-1:0] rise;
   logic [`E1TX_PIN_W-1:0] fall;
   logic [1:0] es_rd;
   logic [8:0] es_wptr;
   logic es_en;
   logic feature_set_select;
   logic line_rise;
   logic line_fall;
   logic txb;
   logic [2:0] lsb_bit;
   logic [4:0] blk_ts;

   // Sa bit in use for link data
   function automatic logic sa_used(input e1tx_pkg::e1tx_pos_t p, input logic [31:0] c);
      logic [4:0] sel;
      sel = c[`E1TX_CTRL_SA_MSB:`E1TX_CTRL_SA_LSB];
      sa_used = 1'b0;
      if (p.ts == 5'h00 && p.frame[0] && p.bit_no >= `E1TX_SA_FIRST_BIT && c[`E1TX_CTRL_LINK_EN]) begin
         sa_used = sel[3'(p.bit_no - `E1TX_SA_FIRST_BIT)];
      end
   endfunction

   // Bit position that follows p
   function automatic e1tx_pkg::e1tx_pos_t pos_step(input e1tx_pkg::e1tx_pos_t p);
      pos_step = p;
      pos_step.bit_no = p.bit_no + 3'h1;
      if (p.bit_no == 3'h7) begin
         pos_step.ts = p.ts + 5'h01;
         if (p.ts == 5'h1F) begin
            pos_step.frame = p.frame + 4'h1;
         end
      end
   endfunction

   // Line bit for position p, overhead first
   function automatic logic fmt_bit(input e1tx_pkg::e1tx_pos_t p, input logic ser, input logic sig,
                                    input logic link, input logic [31:0] c, input logic full_mode);
      fmt_bit = ser;
      if (p.ts == 5'h00) begin
         if (!p.frame[0]) begin
            fmt_bit = FAS[3'h7 - p.bit_no];
         end else if (p.bit_no < `E1TX_SA_FIRST_BIT) begin
            fmt_bit = NFAS[2'(3'h2 - p.bit_no)];
         end else begin
            fmt_bit = sa_used(p, c) ? link : 1'b1;
         end
      end else if (p.ts == `E1TX_TS_CAS && c[`E1TX_CTRL_SIG_EN] && full_mode) begin
         fmt_bit = (p.frame == 4'h0) ? MAS[3'h7 - p.bit_no] : sig;
      end
   endfunction

   assign pins[`E1TX_PIN_LCLK] = i_tx_line_clock;
   assign pins[`E1TX_PIN_SCLK] = i_tx_system_clock;
   assign pins[`E1TX_PIN_SER] = i_tx_ser;
   assign pins[`E1TX_PIN_SIG] = i_tx_sig;
   assign pins[`E1TX_PIN_LINK] = i_tx_link_data;
   assign pins[`E1TX_PIN_SYNC] = i_tx_sync;
   assign pins[`E1TX_PIN_SSYNC] = i_tx_sys_sync;
   assign pins[`E1TX_PIN_FMS] = i_feature_set_select;

   e1tx_pin_sync u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_pins(pins),
      .o_level(lvl),
      .o_rise(rise),
      .o_fall(fall)
   );

   // System clock falls write the store only while it is enabled
   e1tx_elastic u_elastic (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_enable(es_en),
      .i_wr_stb(fall[`E1TX_PIN_SCLK]),
      .i_sync(rise[`E1TX_PIN_SSYNC]),
      .i_wr_data({lvl[`E1TX_PIN_SIG], lvl[`E1TX_PIN_SER]}),
      .i_rd_addr({s.pos.frame[0], s.pos.ts, s.pos.bit_no}),
      .o_rd_data(es_rd),
      .o_wptr(es_wptr)
   );

   assign es_en = s.ctrl[`E1TX_CTRL_ES_EN];
   assign feature_set_select = lvl[`E1TX_PIN_FMS];
   assign line_rise = rise[`E1TX_PIN_LCLK];
   assign line_fall = fall[`E1TX_PIN_LCLK];

   always_comb begin
      next_s = s;
      np = pos_step(s.pos);
      txb = fmt_bit(s.pos, s.ser_s, s.sig_s, s.link_s, s.ctrl, !feature_set_select);
      lsb_bit = es_en ? es_wptr[2:0] : s.pos.bit_no;
      blk_ts = es_en ? es_wptr[7:3] : s.pos.ts;

      // Sampling half of the line bit
      if (line_fall) begin
         next_s.ser_s = es_en ? es_rd[0] : lvl[`E1TX_PIN_SER];
         next_s.sig_s = es_en ? es_rd[1] : lvl[`E1TX_PIN_SIG];
         next_s.link_s = lvl[`E1TX_PIN_LINK];
         if (!s.ctrl[`E1TX_CTRL_SYNC_OUT] && lvl[`E1TX_PIN_SYNC]) begin
            next_s.pos.bit_no = 3'h0;
            next_s.pos.ts = 5'h00;
            if (s.ctrl[`E1TX_CTRL_SYNC_MF]) begin
               next_s.pos.frame = 4'h0;
            end
         end
      end

      // Output half of the line bit
      if (line_rise) begin
         if (s.ctrl[`E1TX_CTRL_NRZ]) begin
            next_s.tx_pos = txb;
            next_s.tx_neg = 1'b0;
         end else if (txb) begin
            next_s.tx_pos = ~s.ami_pol;
            next_s.tx_neg = s.ami_pol;
            next_s.ami_pol = ~s.ami_pol;
         end else begin
            next_s.tx_pos = 1'b0;
            next_s.tx_neg = 1'b0;
         end
         next_s.pos = np;
         next_s.lclk = sa_used(np, s.ctrl);
         next_s.sync_out = s.ctrl[`E1TX_CTRL_SYNC_OUT] && np.ts == 5'h00 && np.bit_no == 3'h0
                           && (!s.ctrl[`E1TX_CTRL_SYNC_MF] || np.frame == 4'h0);
      end

      next_s.chclk = feature_set_select && lsb_bit == 3'h7;
      next_s.chblk = s.chblk_mask[blk_ts];
      next_s.sync_oe_n = ~s.ctrl[`E1TX_CTRL_SYNC_OUT];

      // APB: answer in the access phase after each setup
      next_s.pready = i_psel && !i_penable && !s.pready;
      if (i_psel && !i_penable) begin
         next_s.pslverr = 1'b0;
         next_s.prdata = 32'h0000_0000;
         case (i_paddr)
            `E1TX_ADDR_CTRL: begin
               next_s.prdata = s.ctrl;
            end
            `E1TX_ADDR_CHBLK: begin
               next_s.prdata = s.chblk_mask;
            end
            `E1TX_ADDR_STAT: begin
               next_s.prdata = {19'h0_0000, feature_set_select, s.pos.frame, s.pos.ts, s.pos.bit_no};
            end
            default: begin
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      if (i_psel && i_penable && s.pready && i_pwrite && !s.pslverr) begin
         case (i_paddr)
            `E1TX_ADDR_CTRL: begin
               next_s.ctrl = i_pwdata & `E1TX_CTRL_MASK;
            end
            `E1TX_ADDR_CHBLK: begin
               next_s.chblk_mask = i_pwdata;
            end
            default: begin
               next_s.ctrl = s.ctrl;
            end
         endcase
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s <= '0;
         s.ctrl <= `E1TX_CTRL_RST;
         s.chblk_mask <= `E1TX_CHBLK_RST;
         s.sync_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign o_pready = s.pready;
   assign o_prdata = s.prdata;
   assign o_pslverr = s.pslverr;
   assign o_tx_pos = s.tx_pos;
   assign o_tx_neg = s.tx_neg;
   assign o_tx_channel_clock = s.chclk;
   assign o_tx_channel_block = s.chblk;
   assign o_tx_link_demand_clock = s.lclk;
   assign o_tx_sync = s.sync_out;
   assign o_tx_sync_oe_n = s.sync_oe_n;

   AST_NRZ_NEG_LOW: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && s.ctrl[`E1TX_CTRL_NRZ] |=> !o_tx_neg)
      else $error("Negative output active in NRZ format");

   AST_BIPOLAR_EXCL: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !(o_tx_pos && o_tx_neg))
      else $error("Both line outputs high together");

   AST_OUT_ON_RISE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !line_rise |=> $stable(o_tx_pos) && $stable(o_tx_neg))
      else $error("Line outputs changed without a line clock rise");

   AST_FAS_ZERO: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && s.pos.ts == 5'h00 && !s.pos.frame[0] && s.pos.bit_no == 3'h1 |=> !o_tx_pos && !o_tx_neg)
      else $error("Second alignment bit not sent as zero");

   AST_BIT_ORDER: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && !line_fall && s.pos.bit_no == 3'h7 |=> s.pos.bit_no == 3'h0
      && s.pos.ts == 5'($past(s.pos.ts) + 5'h01))
      else $error("Timeslot did not advance after its last bit");

   AST_CHCLK_LEGACY: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !feature_set_select |=> !o_tx_channel_clock)
      else $error("Channel clock active in full-feature mode");

   AST_CHCLK_LSB: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !$past(es_en) && $rose(o_tx_channel_clock) |-> $past(s.pos.bit_no) == 3'h7)
      else $error("Channel clock not aligned to channel LSB");

   AST_CHBLK_MAP: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !es_en && $stable(s.pos.ts) |=> o_tx_channel_block == $past(s.chblk_mask[s.pos.ts]))
      else $error("Channel block does not follow its channel bit");

   AST_SYNC_OUT_POS: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_tx_sync) |-> s.pos.ts == 5'h00 && s.pos.bit_no == 3'h0)
      else $error("Sync output pulse away from the frame boundary");

   AST_APB_ANSWER: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      i_psel && !i_penable && !o_pready |=> o_pready ##1 !o_pready)
      else $error("APB ready not a single cycle after setup");

   AST_APB_ERR_DATA: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      o_pready && o_pslverr |-> o_prdata == 32'h0000_0000)
      else $error("Unmapped read returned nonzero data");

   AST_SER_SAMPLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_fall && !es_en |=> s.ser_s == $past(lvl[`E1TX_PIN_SER]))
      else $error("Serial data not taken at the line clock fall");

   AST_SER_STORE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_fall && es_en |=> s.ser_s == $past(es_rd[0]))
      else $error("Serial data not taken from the store");

   AST_SIG_SAMPLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_fall && !es_en |=> s.sig_s == $past(lvl[`E1TX_PIN_SIG]))
      else $error("Signaling not taken at the line clock fall");

   AST_SIG_STORE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_fall && es_en |=> s.sig_s == $past(es_rd[1]))
      else $error("Signaling not taken from the store");

   AST_LINK_SAMPLE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_fall |=> s.link_s == $past(lvl[`E1TX_PIN_LINK]))
      else $error("Link data not taken at the line clock fall");

   AST_LINK_INSERT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && s.ctrl[`E1TX_CTRL_NRZ] && sa_used(s.pos, s.ctrl) |=> o_tx_pos == $past(s.link_s))
      else $error("Selected spare bit does not carry link data");

   AST_DEMAND_SA: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      $rose(o_tx_link_demand_clock) |-> s.pos.ts == 5'h00 && s.pos.frame[0]
      && s.pos.bit_no >= `E1TX_SA_FIRST_BIT)
      else $error("Demand clock away from a spare bit");

   AST_NFAS_FIXED: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && s.pos.ts == 5'h00 && s.pos.frame[0] && s.pos.bit_no == 3'h2 |=> !o_tx_pos && !o_tx_neg)
      else $error("Alarm bit of odd frame not sent as zero");

   AST_NFAS_MARK: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && s.ctrl[`E1TX_CTRL_NRZ] && s.pos.ts == 5'h00 && s.pos.frame[0] && s.pos.bit_no == 3'h1
      |=> o_tx_pos)
      else $error("Second bit of odd frame not sent as one");

   AST_FAS_FIRST: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && s.ctrl[`E1TX_CTRL_NRZ] && s.pos.ts == 5'h00 && !s.pos.frame[0] && s.pos.bit_no == 3'h0
      |=> o_tx_pos)
      else $error("First alignment bit not one on NRZ output");

   AST_MARK_ALT: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      line_rise && !s.ctrl[`E1TX_CTRL_NRZ] && s.ami_pol |=> !o_tx_pos)
      else $error("Two marks in a row on the positive output");

   AST_CHCLK_STORE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      es_en && feature_set_select |=> o_tx_channel_clock == ($past(es_wptr[2:0]) == 3'h7))
      else $error("Channel clock not on the system side LSB");

   AST_CHBLK_STORE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      es_en |=> o_tx_channel_block == $past(s.chblk_mask[es_wptr[7:3]]))
      else $error("Channel block not following the system side channel");

   AST_SYNC_OE: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      s.ctrl[`E1TX_CTRL_SYNC_OUT] |=> !o_tx_sync_oe_n)
      else $error("Sync pin not driven in output mode");
endmodule
`default_nettype wire

// ===== e1tx_backplane.sv
// Backplane and line-side partner model for the E1 transmit framer
`timescale 1ns/1ps
`default_nettype none
module e1tx_backplane (
   input wire logic i_link_level,
   input wire logic i_store_on,
   output logic o_line_clock,
   output logic o_sys_clock,
   output logic o_sys_sync,
   output logic o_ser,
   output logic o_sig,
   output logic o_link_data
);
   int nbit;

   // Free-running line clock, 160 ns, phase unrelated to the reference clock
   initial begin
      o_line_clock = 1'b0;
      #3;
      forever begin
         #80 o_line_clock = ~o_line_clock;
      end
   end

   // System clock only while the store is on, low otherwise; one sync per 256 bits
   initial begin
      o_sys_clock = 1'b0;
      o_sys_sync = 1'b0;
      nbit = 0;
      forever begin
         @(posedge o_line_clock);
         #1;
         o_sys_clock = i_store_on;
         o_sys_sync = i_store_on && nbit == 0;
         nbit = (nbit + 1) % 256;
         @(negedge o_line_clock);
         #1;
         o_sys_clock = 1'b0;
      end
   end

   // Data changes just after the line rise, so it is settled at the sampling fall
   initial begin
      o_ser = 1'b0;
      o_sig = 1'b0;
      o_link_data = 1'b1;
      forever begin
         @(posedge o_line_clock);
         #1;
         o_ser = 1'b0;
         o_sig = 1'b0;
         o_link_data = i_link_level;
      end
   end
endmodule
`default_nettype wire

// ===== e1_transmit_side_interface_tb.sv
// Self-checking bench for the E1 transmit framer
`timescale 1ns/1ps
`default_nettype none
`include "e1tx_map.svh"
module e1_transmit_side_interface_tb;
   logic i_ref_clk = 1'b0;
   logic i_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic pready, pslverr, tx_pos, tx_neg, ch_clk, ch_blk, demand, sync_o, sync_oe_n;
   logic [31:0] prdata;
   logic line_clk, sys_clk, sys_sync, ser, sig, link_data, sync_pin;
   logic fsel = 1'b0;
   logic link_level = 1'b1;
   logic store_on = 1'b0;
   logic [31:0] q;
   logic e;
   int errors = 0;
   int n_compared = 0;
   int n_pos, n_neg, n_both, n_chclk, n_chblk, n_dem, n_sync;

   always #5 i_ref_clk = ~i_ref_clk;

   // Sync pin has a pull-down; device drives it when its enable is low
   assign sync_pin = sync_oe_n ? 1'b0 : sync_o;

   e1tx_backplane partner (.i_link_level(link_level), .i_store_on(store_on), .o_line_clock(line_clk),
      .o_sys_clock(sys_clk),
      .o_sys_sync(sys_sync), .o_ser(ser), .o_sig(sig), .o_link_data(link_data));

   e1tx_framer dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
      .o_pslverr(pslverr), .i_tx_line_clock(line_clk), .i_tx_system_clock(sys_clk), .i_tx_ser(ser),
      .i_tx_sig(sig), .i_tx_link_data(link_data), .i_tx_sync(sync_pin), .i_tx_sys_sync(sys_sync),
      .i_feature_set_select(fsel), .o_tx_pos(tx_pos), .o_tx_neg(tx_neg), .o_tx_channel_clock(ch_clk),
      .o_tx_channel_block(ch_blk), .o_tx_link_demand_clock(demand), .o_tx_sync(sync_o),
      .o_tx_sync_oe_n(sync_oe_n));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("compared=%0d mismatches=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // One APB transfer: setup, then access until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge i_ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge i_ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         chk(32'h0000_0000, 32'h0000_0001);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Count line bits where each output is high, sampled mid-bit at the line fall
   task automatic measure(input int nbits);
      repeat (32) @(negedge line_clk);
      n_pos = 0;
      n_neg = 0;
      n_both = 0;
      n_chclk = 0;
      n_chblk = 0;
      n_dem = 0;
      n_sync = 0;
      repeat (nbits) begin
         @(negedge line_clk);
         n_pos += (tx_pos === 1'b1);
         n_neg += (tx_neg === 1'b1);
         n_both += (tx_pos === 1'b1 && tx_neg === 1'b1);
         n_chclk += (ch_clk === 1'b1);
         n_chblk += (ch_blk === 1'b1);
         n_dem += (demand === 1'b1);
         n_sync += (sync_o === 1'b1 && sync_oe_n === 1'b0);
      end
   endtask

   initial begin
      #600_000;
      errors++;
      give_verdict();
   end

   initial begin
      repeat (20) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      // Register reset values, masking, unmapped place
      apb(1'b0, `E1TX_ADDR_CTRL, 32'h0);
      chk(q, `E1TX_CTRL_RST);
      apb(1'b0, `E1TX_ADDR_CHBLK, 32'h0);
      chk(q, `E1TX_CHBLK_RST);
      apb(1'b1, `E1TX_ADDR_CTRL, 32'hFFFF_FFFF);
      apb(1'b0, `E1TX_ADDR_CTRL, 32'h0);
      chk(q, `E1TX_CTRL_MASK);
      apb(1'b0, 12'h00C, 32'h0);
      chk({q[30:0], e}, 32'h0000_0001);
      fsel <= 1'b1;
      repeat (4) @(posedge i_ref_clk);
      apb(1'b0, `E1TX_ADDR_STAT, 32'h0);
      chk({31'h0, q[12]}, 32'h0000_0001);
      $display("test registers done");
      // NRZ, legacy mode, frame sync output, three blocked channels
      apb(1'b1, `E1TX_ADDR_CTRL, 32'h0000_0006);
      apb(1'b1, `E1TX_ADDR_CHBLK, 32'h0001_0005);
      measure(512);
      chk({31'h0, sync_oe_n}, 32'h0000_0000);
      chk(32'(n_pos), 32'h0000_000C);
      chk(32'(n_chclk), 32'h0000_0040);
      chk(32'(n_chblk), 32'h0000_0030);
      chk(32'(n_sync), 32'h0000_0002);
      $display("test nrz strobes done");
      // Bipolar output, full mode, all Sa bits from link data high
      fsel <= 1'b0;
      apb(1'b1, `E1TX_ADDR_CHBLK, 32'h0000_0000);
      apb(1'b1, `E1TX_ADDR_CTRL, 32'h0000_1F10);
      measure(512);
      chk(32'(n_pos), 32'h0000_0006);
      chk(32'(n_neg), 32'h0000_0006);
      chk(32'(n_both), 32'h0000_0000);
      chk(32'(n_chclk), 32'h0000_0000);
      chk(32'(n_chblk), 32'h0000_0000);
      chk(32'(n_dem), 32'h0000_0005);
      chk({31'h0, sync_oe_n}, 32'h0000_0001);
      $display("test bipolar done");
      // Link data low replaces the five Sa bits
      link_level <= 1'b0;
      apb(1'b1, `E1TX_ADDR_CTRL, 32'h0000_1F12);
      measure(512);
      chk(32'(n_pos), 32'h0000_0007);
      chk(32'(n_dem), 32'h0000_0005);
      $display("test link insertion done");
      // Store on, legacy mode, strobes on the system side
      fsel <= 1'b1;
      store_on <= 1'b1;
      apb(1'b1, `E1TX_ADDR_CHBLK, 32'h8000_0001);
      apb(1'b1, `E1TX_ADDR_CTRL, 32'h0000_0003);
      repeat (256) @(negedge line_clk);
      measure(512);
      chk(32'(n_pos), 32'h0000_000C);
      chk(32'(n_neg), 32'h0000_0000);
      chk(32'(n_chclk), 32'h0000_0040);
      chk(32'(n_chblk), 32'h0000_0020);
      $display("test elastic store done");
      give_verdict();
   end
endmodule
`default_nettype wire
